// ===== mscl_pkg.sv
// Package with register map, field layout and decode tables for the start-up and closed-loop configuration block.
package mscl_pkg;

    // ------------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------------
    localparam logic [11:0] CLOSED_LOOP_CONFIG_ONE_OFFSET = 12'h088;
    localparam logic [11:0] STARTUP_CONFIG_TWO_OFFSET     = 12'h084;
    localparam logic [31:0] CLOSED_LOOP_CONFIG_ONE_RESET  = 32'h0000_0000;
    localparam logic [31:0] STARTUP_CONFIG_TWO_RESET      = 32'h0000_0000;
    localparam logic [31:0] STARTUP_CONFIG_TWO_WMASK      = 32'h7FFF_FFFF;
    localparam logic [31:0] CLOSED_LOOP_CONFIG_ONE_WMASK  = 32'h7FFF_FFFF;
    localparam logic [31:0] ZERO_WORD                     = 32'h0000_0000;

    // ------------------------------------------------------------------
    // Field layout
    // ------------------------------------------------------------------
    localparam int ALIGN_ANGLE_LSB   = 8;
    localparam int ALIGN_ANGLE_MSB   = 12;
    localparam int INIT_SPEED_LSB    = 4;
    localparam int INIT_SPEED_MSB    = 7;
    localparam int FIRST_FREQ_SEL    = 3;
    localparam int SLEW_LSB          = 0;
    localparam int SLEW_MSB          = 2;
    localparam int OVERMOD_EN_BIT    = 30;

    localparam logic [4:0] ALIGN_LAST_VALID = 5'h1C;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    // Align angle in whole degrees; reserved codes decode to zero.
    function automatic logic [8:0] mscl_align_deg(input logic [4:0] code);
        logic [8:0] t [0:28];
        t = '{9'd0, 9'd10, 9'd20, 9'd30, 9'd45, 9'd60, 9'd70, 9'd80, 9'd90, 9'd110,
              9'd120, 9'd135, 9'd150, 9'd160, 9'd170, 9'd180, 9'd190, 9'd210, 9'd225,
              9'd240, 9'd250, 9'd260, 9'd270, 9'd280, 9'd290, 9'd315, 9'd330, 9'd340, 9'd350};
        return (code <= ALIGN_LAST_VALID) ? t[code] : 9'd0;
    endfunction

    // Initial-cycle speed in tenths of a percent of top speed.
    function automatic logic [8:0] mscl_speed_pm(input logic [3:0] code);
        logic [8:0] t [0:15];
        t = '{9'd10, 9'd20, 9'd30, 9'd50, 9'd75, 9'd100, 9'd125, 9'd150,
              9'd175, 9'd200, 9'd250, 9'd300, 9'd350, 9'd400, 9'd450, 9'd500};
        return t[code];
    endfunction

    // Angle-error slew in hundredths of a degree per millisecond.
    function automatic logic [7:0] mscl_slew_cdpm(input logic [2:0] code);
        logic [7:0] t [0:7];
        t = '{8'd1, 8'd5, 8'd10, 8'd15, 8'd20, 8'd50, 8'd100, 8'd200};
        return t[code];
    endfunction

endpackage

// ===== mscl_cfg_if.sv
// Interface carrying register write strobes and stored words between the bus slave and the register file.
`timescale 1ns/1ps
interface mscl_cfg_if;
    logic        wr_startup;
    logic        wr_closed;
    logic [31:0] wdata;
    logic [31:0] startup_word;
    logic [31:0] closed_word;

    modport slave (output wr_startup, output wr_closed, output wdata, input startup_word, input closed_word);
    modport regs  (input wr_startup, input wr_closed, input wdata, output startup_word, output closed_word);
endinterface

// ===== mscl_apb_slave.sv
// APB slave that decodes the two configuration words and answers with zero wait states.
`timescale 1ns/1ps
module mscl_apb_slave (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    mscl_cfg_if.slave        cfg
);
    logic        access;
    logic        setup;
    logic        hit_su;
    logic        hit_cl;
    logic [31:0] rdata_d;

    assign access = psel && penable && pready;
    assign setup  = psel && !penable;
    assign hit_su = (paddr == mscl_pkg::STARTUP_CONFIG_TWO_OFFSET);
    assign hit_cl = (paddr == mscl_pkg::CLOSED_LOOP_CONFIG_ONE_OFFSET);

    assign cfg.wdata      = pwdata;
    assign cfg.wr_startup = access && pwrite && hit_su;
    assign cfg.wr_closed  = access && pwrite && hit_cl;

    // Unmapped addresses read zero.
    always_comb begin
        rdata_d = mscl_pkg::ZERO_WORD;
        if (hit_su) begin
            rdata_d = cfg.startup_word;
        end else if (hit_cl) begin
            rdata_d = cfg.closed_word;
        end
    end

    // Answer is prepared in the setup cycle so the access phase needs no wait state.
    always_ff @(posedge core_clk) begin
        if (srst) begin
            pready <= 1'b0;
        end else begin
            pready <= setup;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            prdata <= mscl_pkg::ZERO_WORD;
        end else if (setup) begin
            prdata <= rdata_d;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            pslverr <= 1'b0;
        end else begin
            pslverr <= setup && !(hit_su || hit_cl);
        end
    end
endmodule // mscl_apb_slave

// ===== mscl_regs.sv
// Storage for the start-up and closed-loop configuration words.
`timescale 1ns/1ps
module mscl_regs (
    input  wire logic core_clk,
    input  wire logic srst,
    mscl_cfg_if.regs  cfg
);
    logic [31:0] startup_q;
    logic [31:0] closed_q;

    always_ff @(posedge core_clk) begin
        if (srst) begin
            startup_q <= mscl_pkg::STARTUP_CONFIG_TWO_RESET;
        end else if (cfg.wr_startup) begin
            startup_q <= cfg.wdata & mscl_pkg::STARTUP_CONFIG_TWO_WMASK;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            closed_q <= mscl_pkg::CLOSED_LOOP_CONFIG_ONE_RESET;
        end else if (cfg.wr_closed) begin
            closed_q <= cfg.wdata & mscl_pkg::CLOSED_LOOP_CONFIG_ONE_WMASK;
        end
    end

    assign cfg.startup_word = startup_q;
    assign cfg.closed_word  = closed_q;
endmodule // mscl_regs

// ===== mscl_top.sv
// Top of the start-up and closed-loop configuration block: APB registers and decoded field outputs.
//
// How it works
// - The five-bit align field at bits 12..8 decodes codes 0h..1Ch to 0..350 degrees; 1Dh..1Fh are reserved.
// - The four-bit field at bits 7..4 gives the first-cycle speed, 1 percent at 0h up to 50 percent at Fh.
// - Bit 3 selects 0 Hz when clear, or the initial-cycle speed when set, for align and probe start-ups.
// - The three-bit field at bits 2..0 sets the angle-error slew, 0.01 deg/ms at 0h to 2 deg/ms at 7h.
// - The closed-loop word sits at offset 88h and resets to all zeros.
// - Bit 30 of the closed-loop word is read-write and enables overmodulation when set, reset zero.
`timescale 1ns/1ps
module mscl_top (
    input  wire logic        core_clk,
    input  wire logic        srst,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    output logic      [8:0]  align_angle_deg,
    output logic             align_code_reserved,
    output logic      [8:0]  first_cycle_speed_pm,
    output logic      [8:0]  open_loop_first_speed_pm,
    output logic      [7:0]  angle_slew_cdpm,
    output logic             overmod_enable
);
    // ------------------------------------------------------------------
    // Registers and bus
    // ------------------------------------------------------------------
    mscl_cfg_if cfg ();

    mscl_apb_slave u_slave (
        .core_clk (core_clk),
        .srst     (srst),
        .psel     (psel),
        .penable  (penable),
        .pwrite   (pwrite),
        .paddr    (paddr),
        .pwdata   (pwdata),
        .prdata   (prdata),
        .pready   (pready),
        .pslverr  (pslverr),
        .cfg      (cfg)
    );

    mscl_regs u_regs (
        .core_clk (core_clk),
        .srst     (srst),
        .cfg      (cfg)
    );

    // ------------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------------
    logic [4:0] align_code;
    logic [3:0] speed_code;
    logic [2:0] slew_code;

    assign align_code = cfg.startup_word[mscl_pkg::ALIGN_ANGLE_MSB:mscl_pkg::ALIGN_ANGLE_LSB];
    assign speed_code = cfg.startup_word[mscl_pkg::INIT_SPEED_MSB:mscl_pkg::INIT_SPEED_LSB];
    assign slew_code  = cfg.startup_word[mscl_pkg::SLEW_MSB:mscl_pkg::SLEW_LSB];

    always_ff @(posedge core_clk) begin
        if (srst) begin
            align_angle_deg     <= '0;
            align_code_reserved <= 1'b0;
        end else begin
            align_angle_deg     <= mscl_pkg::mscl_align_deg(align_code);
            align_code_reserved <= (align_code > mscl_pkg::ALIGN_LAST_VALID);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            first_cycle_speed_pm <= '0;
        end else begin
            first_cycle_speed_pm <= mscl_pkg::mscl_speed_pm(speed_code);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            open_loop_first_speed_pm <= '0;
        end else if (cfg.startup_word[mscl_pkg::FIRST_FREQ_SEL]) begin
            open_loop_first_speed_pm <= mscl_pkg::mscl_speed_pm(speed_code);
        end else begin
            open_loop_first_speed_pm <= '0;
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            angle_slew_cdpm <= '0;
        end else begin
            angle_slew_cdpm <= mscl_pkg::mscl_slew_cdpm(slew_code);
        end
    end

    always_ff @(posedge core_clk) begin
        if (srst) begin
            overmod_enable <= 1'b0;
        end else begin
            overmod_enable <= cfg.closed_word[mscl_pkg::OVERMOD_EN_BIT];
        end
    end
endmodule // mscl_top

// ===== mscl_checker.sv
// Port-level checker for the configuration block, bound to the top module.
`timescale 1ns/1ps
module mscl_checker (
    input wire logic        core_clk,
    input wire logic        srst,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pslverr,
    input wire logic [8:0]  align_angle_deg,
    input wire logic        align_code_reserved,
    input wire logic [8:0]  first_cycle_speed_pm,
    input wire logic [8:0]  open_loop_first_speed_pm,
    input wire logic [7:0]  angle_slew_cdpm,
    input wire logic        overmod_enable
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    wire acc = psel && penable;
    wire w84 = acc && pwrite && paddr == 12'h084;
    wire w88 = acc && pwrite && paddr == 12'h088;
    a_align_last_code: assert property (w84 && pwdata[12:8] == 5'h1C |->
        ##2 align_angle_deg == 9'd350 && !align_code_reserved) else $error("align decode wrong");
    a_speed_low_end: assert property (w84 && pwdata[7:4] == 4'h0 |-> ##2 first_cycle_speed_pm == 9'd10)
        else $error("speed low wrong");
    a_speed_high_end: assert property (w84 && pwdata[7:4] == 4'hF |-> ##2 first_cycle_speed_pm == 9'd500)
        else $error("speed high wrong");
    a_open_loop_zero: assert property (w84 && !pwdata[3] |-> ##2 open_loop_first_speed_pm == 9'd0)
        else $error("open loop not zero");
    a_open_loop_follow: assert property (open_loop_first_speed_pm != 9'd0 |->
        open_loop_first_speed_pm == first_cycle_speed_pm) else $error("open loop mismatch");
    a_slew_top_code: assert property (w84 && pwdata[2:0] == 3'h7 |-> ##2 angle_slew_cdpm == 8'd200)
        else $error("slew decode wrong");
    a_closed_read_ok: assert property (acc && !pwrite && paddr == 12'h088 |-> !pslverr && !prdata[31])
        else $error("closed word read bad");
    a_overmod_write: assert property (w88 |-> ##2 overmod_enable == $past(pwdata[30], 2))
        else $error("overmod not updated");
    cover property (w84);
    cover property (w88 && pwdata[30]);
    cover property (acc && pslverr);
endmodule // mscl_checker

bind mscl_top mscl_checker i_mscl_checker (.*);

// ===== mscl_tb_top.sv
// Self-checking bench comparing the configuration block against a table model.
`timescale 1ns/1ps
module mscl_tb_top;
    logic        core_clk = 1'b0;
    logic        srst     = 1'b1;
    logic        psel     = 1'b0;
    logic        penable  = 1'b0;
    logic        pwrite   = 1'b0;
    logic [11:0] paddr    = 12'h000;
    logic [31:0] pwdata   = 32'h0000_0000;
    logic [31:0] prdata, rd, v;
    logic        pready, pslverr, align_code_reserved, overmod_enable, er;
    logic [8:0]  align_angle_deg, first_cycle_speed_pm, open_loop_first_speed_pm;
    logic [7:0]  angle_slew_cdpm;
    int          error_cnt = 0;
    int          n_tests   = 0;
    int          seed      = 94;
    int al[29] = '{0, 10, 20, 30, 45, 60, 70, 80, 90, 110, 120, 135, 150, 160, 170, 180, 190, 210, 225,
                   240, 250, 260, 270, 280, 290, 315, 330, 340, 350};
    int sp[16] = '{10, 20, 30, 50, 75, 100, 125, 150, 175, 200, 250, 300, 350, 400, 450, 500};
    int sl[8]  = '{1, 5, 10, 15, 20, 50, 100, 200};

    always #12.5 core_clk = ~core_clk;

    mscl_top i_mscl_top (.*);

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            error_cnt++;
            $display("Error t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    task automatic wrap_up();
        if (error_cnt == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    initial begin
        repeat (2000) @(posedge core_clk);
        error_cnt++;
        wrap_up();
    end

    initial begin
        repeat (12) @(posedge core_clk);
        srst <= 1'b0;
        apb(1'b0, 12'h088, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(er, 1'b0);
        apb(1'b0, 12'h0C0, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(er, 1'b1);
        for (int i = 0; i < 32; i++) begin
            v = $random(seed);
            v[12:8] = i[4:0];
            v[7:4] = i[3:0];
            v[2:0] = i[2:0];
            apb(1'b1, 12'h084, v);
            apb(1'b0, 12'h084, 32'h0000_0000);
            chk(rd, v & 32'h7FFF_FFFF);
            chk(align_angle_deg, i < 29 ? al[i] : 0);
            chk(align_code_reserved, i > 28);
            chk(first_cycle_speed_pm, sp[v[7:4]]);
            chk(open_loop_first_speed_pm, v[3] ? sp[v[7:4]] : 0);
            chk(angle_slew_cdpm, sl[v[2:0]]);
        end
        for (int b = 1; b >= 0; b--) begin
            v = $random(seed);
            v[30] = b[0];
            apb(1'b1, 12'h088, v);
            apb(1'b0, 12'h088, 32'h0000_0000);
            chk(rd, v & 32'h7FFF_FFFF);
            chk(overmod_enable, b);
        end
        apb(1'b1, 12'h088, 32'h4000_0000);
        srst <= 1'b1;
        @(posedge core_clk);
        srst <= 1'b0;
        apb(1'b0, 12'h088, 32'h0000_0000);
        chk(rd, 32'h0000_0000);
        chk(overmod_enable, 0);
        wrap_up();
    end
endmodule // mscl_tb_top
